// ### src/e1pm_consts.svh
`ifndef E1PM_CONSTS_SVH
`define E1PM_CONSTS_SVH

// Register byte offsets.
`define E1PM_OFS_CTRL 8'h00
`define E1PM_OFS_DEGRADE 8'h04
`define E1PM_OFS_STATUS 8'h08
`define E1PM_OFS_NEAR 8'h0c
`define E1PM_OFS_FAR 8'h10
`define E1PM_OFS_INT_STATUS 8'h14
`define E1PM_OFS_INT_MASK 8'h18

// Control register fields.
`define E1PM_CTRL_MON_BIT 0
`define E1PM_CTRL_RDI_REP_BIT 1
`define E1PM_CTRL_SSF_REP_BIT 2
`define E1PM_CTRL_TP_BIT 3
`define E1PM_CTRL_CRC_LSB 4
`define E1PM_CTRL_CRC_MSB 5

// Degrade register fields.
`define E1PM_DEG_WIN_LSB 0
`define E1PM_DEG_WIN_MSB 3
`define E1PM_DEG_THR_LSB 16
`define E1PM_DEG_THR_MSB 31

// Status register fields; the defect second bit of the counter registers is the last one below.
`define E1PM_ST_TSF_BIT 0
`define E1PM_ST_DEG_BIT 1
`define E1PM_ST_RDI_BIT 2
`define E1PM_ST_RNCI_BIT 3
`define E1PM_ST_MFP_BIT 4
`define E1PM_ST_DEGRADED_CAUSE_BIT 5
`define E1PM_ST_REMOTE_DEFECT_CAUSE_BIT 6
`define E1PM_ST_SERVER_FAIL_CAUSE_BIT 7
`define E1PM_CNT_DS_BIT 16

// Interrupt bits.
`define E1PM_INT_SECOND 0
`define E1PM_INT_DEG 1
`define E1PM_INT_RDI 2
`define E1PM_INT_RNCI 3
`define E1PM_INT_SSF 4
`define E1PM_INT_W 5

// Reset values.
`define E1PM_RST_MON 1'b1
`define E1PM_RST_RDI_REP 1'b0
`define E1PM_RST_SSF_REP 1'b0
`define E1PM_RST_DEG_WIN 4'h7
`define E1PM_RST_DEG_THR 16'h0064
`define E1PM_RST_MASK 5'h00

// Line constants and counts.
`define E1PM_FAS_WORD 7'h1b
`define E1PM_RDI_FRAMES 3'h5
`define E1PM_RNCI_SECONDS 3'h5
`define E1PM_RNCI_LIMIT 16'd990
`define E1PM_FRAME_E1 4'hd
`define E1PM_FRAME_E2 4'hf

`endif

// ### src/e1pm_pkg.sv
package e1pm_pkg;

    typedef enum logic [1:0] {
        E1PM_CRC_OFF = 2'b00,
        E1PM_CRC_ON = 2'b01,
        E1PM_CRC_AUTO = 2'b10
    } e1pm_crc_mode_e;

    typedef logic [15:0] e1pm_count_t;

    typedef struct packed {
        logic [3:0] state;
        logic [3:0] last;
    } e1pm_crc_s;

    typedef struct packed {
        logic [1:0] ck_s;
        logic [1:0] data_s;
        logic [1:0] fs_s;
        logic [1:0] mfs_s;
        logic [1:0] ssf_s;
        logic [1:0] mfp_s;
        logic [1:0] sec_s;
        logic ck_prev;
        logic sec_prev;
        logic [7:0] bit_pos;
        logic [3:0] frame_no;
        logic [5:0] fas_sh;
        logic [3:0] c_bits;
        logic crc_armed;
        logic crc_exp_ok;
        logic [2:0] rdi_one_run;
        logic [2:0] rdi_zero_run;
        logic remote_defect_flag;
        e1pm_count_t near_acc;
        e1pm_count_t far_acc;
        e1pm_count_t deg_acc;
        logic near_ds_acc;
        logic far_ds_acc;
        e1pm_count_t near_error_count;
        e1pm_count_t far_error_count;
        logic near_defect_second;
        logic far_defect_second;
        logic [3:0] bad_run;
        logic [3:0] good_run;
        logic degraded_flag;
        logic [2:0] set_run;
        logic [2:0] clr_run;
        logic crc_interwork_status;
        logic monitoring_active;
        logic remote_defect_report_en;
        logic server_fail_report_en;
        logic termination_point_setting;
        e1pm_crc_mode_e crc_interwork_setting;
        logic [3:0] degrade_window_count;
        e1pm_count_t degrade_threshold;
        logic [4:0] int_status;
        logic [4:0] int_mask;
        logic trail_fail_action;
        logic trail_degrade_action;
        logic degraded_cause;
        logic remote_defect_cause;
        logic server_fail_cause;
        logic multiframe_present_report;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } e1pm_state_s;

endpackage

// ### src/e1pm_crc4.sv
`timescale 1ns/1ps

// Serial CRC-4 divider, polynomial x^4 + x + 1, C1 in the top bit.
// On a restart the finished remainder moves to last and the new block begins.
module e1pm_crc4 (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Bit stream.
    input wire logic bit_valid,
    input wire logic restart,
    input wire logic din,
    // Remainder of the previous block.
    output logic [3:0] crc_last
);
    import e1pm_pkg::*;

    e1pm_crc_s r;
    e1pm_crc_s next_r;

    function automatic logic [3:0] crc_step(input logic [3:0] s, input logic b);
        logic fb;
        fb = b ^ s[3];
        crc_step = {s[2:0], 1'b0} ^ (fb ? 4'h3 : 4'h0);
    endfunction

    always_comb begin
        next_r = r;
        if (bit_valid) begin
            if (restart) begin
                next_r.last = r.state;
                next_r.state = crc_step(4'h0, din);
            end else begin
                next_r.state = crc_step(r.state, din);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign crc_last = r.last;
endmodule

// ### src/e1pm_monitor.sv
`timescale 1ns/1ps
`include "e1pm_consts.svh"

module e1pm_monitor (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // APB register bus.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // Incoming path signal from the adaptation sink.
    input wire logic line_data,
    input wire logic line_clock,
    input wire logic frame_start,
    input wire logic multiframe_start,
    input wire logic server_fail_in,
    input wire logic multiframe_present_in,
    input wire logic one_second,
    input wire logic equipment_defect,
    // Consequent actions and fault causes.
    output logic trail_fail_action,
    output logic trail_degrade_action,
    output logic degraded_cause,
    output logic remote_defect_cause,
    output logic server_fail_cause,
    output logic crc_interwork_status,
    output logic multiframe_present_report,
    output logic irq
);
    import e1pm_pkg::*;

    e1pm_state_s r;
    e1pm_state_s next_r;
    logic [3:0] crc_last;
    logic ck_edge;
    logic bit_in;
    logic mfp;
    logic [7:0] pos;
    logic [3:0] frm;
    logic smf_start;
    logic near_err;
    logic far_err;
    logic tick;
    logic access;
    logic [4:0] events;
    logic [4:0] w1c;
    logic [31:0] rd;

    function automatic logic reg_mapped(input logic [7:0] a);
        reg_mapped = (a == `E1PM_OFS_CTRL) || (a == `E1PM_OFS_DEGRADE) ||
            (a == `E1PM_OFS_STATUS) || (a == `E1PM_OFS_NEAR) ||
            (a == `E1PM_OFS_FAR) || (a == `E1PM_OFS_INT_STATUS) ||
            (a == `E1PM_OFS_INT_MASK);
    endfunction

    function automatic e1pm_count_t sat_inc(input e1pm_count_t v, input logic en);
        sat_inc = (en && v != 16'hffff) ? v + 16'h0001 : v;
    endfunction

    // The submultiframe remainder is formed with the C bit positions as zero.
    e1pm_crc4 u_crc (
        .clk(clk),
        .rst(rst),
        .bit_valid(ck_edge),
        .restart(smf_start),
        .din(bit_in & ~(pos == 8'h00 && frm[0] == 1'b0)),
        .crc_last(crc_last)
    );

    always_comb begin
        next_r = r;
        ck_edge = r.ck_s[1] & ~r.ck_prev;
        tick = r.sec_s[1] & ~r.sec_prev;
        bit_in = r.data_s[1];
        mfp = r.mfp_s[1];
        pos = r.fs_s[1] ? 8'h00 : r.bit_pos + 8'h01;
        frm = r.fs_s[1] ? (r.mfs_s[1] ? 4'h0 : r.frame_no + 4'h1) : r.frame_no;
        smf_start = (pos == 8'h00) && (frm[2:0] == 3'h0);
        near_err = 1'b0;
        far_err = 1'b0;
        events = '0;
        w1c = '0;
        rd = '0;
        access = psel & penable;

        next_r.ck_s = {r.ck_s[0], line_clock};
        next_r.data_s = {r.data_s[0], line_data};
        next_r.fs_s = {r.fs_s[0], frame_start};
        next_r.mfs_s = {r.mfs_s[0], multiframe_start};
        next_r.ssf_s = {r.ssf_s[0], server_fail_in};
        next_r.mfp_s = {r.mfp_s[0], multiframe_present_in};
        next_r.sec_s = {r.sec_s[0], one_second};
        next_r.ck_prev = r.ck_s[1];
        next_r.sec_prev = r.sec_s[1];

        // Overhead bits are only read; the path signal is never driven.
        if (ck_edge) begin
            next_r.bit_pos = pos;
            next_r.frame_no = frm;
            if (frm[0] == 1'b0) begin
                if (pos >= 8'h01 && pos <= 8'h06) begin
                    next_r.fas_sh = {r.fas_sh[4:0], bit_in};
                end
                if (pos == 8'h07 && !mfp) begin
                    near_err = ({r.fas_sh, bit_in} != `E1PM_FAS_WORD);
                end
                if (pos == 8'h00) begin
                    next_r.c_bits = {r.c_bits[2:0], bit_in};
                    if (frm[2:0] == 3'h6 && mfp && r.crc_exp_ok) begin
                        near_err = ({r.c_bits[2:0], bit_in} != crc_last);
                    end
                end
            end else if (pos == 8'h02) begin
                // A one in the remote defect bit is a defect, zero is normal.
                if (bit_in) begin
                    next_r.rdi_zero_run = 3'h0;
                    if (r.rdi_one_run != `E1PM_RDI_FRAMES) begin
                        next_r.rdi_one_run = r.rdi_one_run + 3'h1;
                    end
                end else begin
                    next_r.rdi_one_run = 3'h0;
                    if (r.rdi_zero_run != `E1PM_RDI_FRAMES) begin
                        next_r.rdi_zero_run = r.rdi_zero_run + 3'h1;
                    end
                end
            end
            if (pos == 8'h00 && (frm == `E1PM_FRAME_E1 || frm == `E1PM_FRAME_E2)) begin
                far_err = mfp & ~bit_in;
            end
            if (smf_start) begin
                next_r.crc_exp_ok = r.crc_armed & mfp;
                next_r.crc_armed = mfp;
            end
        end
        if (!mfp) begin
            next_r.crc_armed = 1'b0;
            next_r.crc_exp_ok = 1'b0;
        end

        // Defect flag after a run of equal remote defect bits.
        if (next_r.rdi_one_run == `E1PM_RDI_FRAMES) begin
            next_r.remote_defect_flag = 1'b1;
        end else if (next_r.rdi_zero_run == `E1PM_RDI_FRAMES) begin
            next_r.remote_defect_flag = 1'b0;
        end

        // Near errors are alignment-word or CRC errors, chosen by multiframe presence.
        next_r.near_acc = sat_inc(r.near_acc, near_err);
        next_r.far_acc = sat_inc(r.far_acc, far_err);
        next_r.deg_acc = sat_inc(r.deg_acc, near_err & mfp);
        next_r.near_ds_acc = r.near_ds_acc | r.trail_fail_action | equipment_defect;
        next_r.far_ds_acc = r.far_ds_acc | r.remote_defect_flag;

        if (tick) begin
            next_r.near_error_count = r.near_acc;
            next_r.far_error_count = r.far_acc;
            next_r.near_defect_second = r.near_ds_acc;
            next_r.far_defect_second = r.far_ds_acc;
            next_r.near_acc = sat_inc(16'h0000, near_err);
            next_r.far_acc = sat_inc(16'h0000, far_err);
            next_r.deg_acc = sat_inc(16'h0000, near_err & mfp);
            next_r.near_ds_acc = r.trail_fail_action | equipment_defect;
            next_r.far_ds_acc = r.remote_defect_flag;
            if (r.deg_acc >= r.degrade_threshold) begin
                next_r.good_run = 4'h0;
                if (r.bad_run < r.degrade_window_count) begin
                    next_r.bad_run = r.bad_run + 4'h1;
                end
            end else begin
                next_r.bad_run = 4'h0;
                if (r.good_run < r.degrade_window_count) begin
                    next_r.good_run = r.good_run + 4'h1;
                end
            end
            if (r.far_acc > `E1PM_RNCI_LIMIT && !r.far_ds_acc) begin
                next_r.clr_run = 3'h0;
                if (r.set_run != `E1PM_RNCI_SECONDS) begin
                    next_r.set_run = r.set_run + 3'h1;
                end
            end else if (r.far_acc < `E1PM_RNCI_LIMIT || r.far_ds_acc) begin
                next_r.set_run = 3'h0;
                if (r.clr_run != `E1PM_RNCI_SECONDS) begin
                    next_r.clr_run = r.clr_run + 3'h1;
                end
            end else begin
                next_r.set_run = 3'h0;
                next_r.clr_run = 3'h0;
            end
        end

        if (next_r.bad_run == r.degrade_window_count && next_r.bad_run != 4'h0) begin
            next_r.degraded_flag = 1'b1;
        end else if (next_r.good_run == r.degrade_window_count) begin
            next_r.degraded_flag = 1'b0;
        end
        if (!mfp) begin
            next_r.degraded_flag = 1'b0;
            next_r.bad_run = 4'h0;
            next_r.good_run = 4'h0;
        end

        if (next_r.set_run == `E1PM_RNCI_SECONDS) begin
            next_r.crc_interwork_status = 1'b1;
        end else if (next_r.clr_run == `E1PM_RNCI_SECONDS) begin
            next_r.crc_interwork_status = 1'b0;
        end
        // The mode setting must match the one given to the adaptation sink.
        if (r.crc_interwork_setting != E1PM_CRC_AUTO) begin
            next_r.crc_interwork_status = 1'b0;
            next_r.set_run = 3'h0;
            next_r.clr_run = 3'h0;
        end

        next_r.trail_fail_action = r.ssf_s[1];
        next_r.trail_degrade_action = r.degraded_flag;
        next_r.multiframe_present_report = mfp;
        next_r.degraded_cause = r.degraded_flag & r.monitoring_active;
        next_r.remote_defect_cause = r.remote_defect_flag & r.monitoring_active &
            r.remote_defect_report_en;
        next_r.server_fail_cause = r.ssf_s[1] & r.monitoring_active &
            r.server_fail_report_en;

        events[`E1PM_INT_SECOND] = tick;
        events[`E1PM_INT_DEG] = next_r.degraded_flag ^ r.degraded_flag;
        events[`E1PM_INT_RDI] = next_r.remote_defect_flag ^ r.remote_defect_flag;
        events[`E1PM_INT_RNCI] = next_r.crc_interwork_status ^ r.crc_interwork_status;
        events[`E1PM_INT_SSF] = r.ssf_s[1] ^ r.trail_fail_action;

        unique case (paddr)
            `E1PM_OFS_CTRL: begin
                rd[`E1PM_CTRL_MON_BIT] = r.monitoring_active;
                rd[`E1PM_CTRL_RDI_REP_BIT] = r.remote_defect_report_en;
                rd[`E1PM_CTRL_SSF_REP_BIT] = r.server_fail_report_en;
                rd[`E1PM_CTRL_TP_BIT] = r.termination_point_setting;
                rd[`E1PM_CTRL_CRC_MSB:`E1PM_CTRL_CRC_LSB] = r.crc_interwork_setting;
            end
            `E1PM_OFS_DEGRADE: begin
                rd[`E1PM_DEG_WIN_MSB:`E1PM_DEG_WIN_LSB] = r.degrade_window_count;
                rd[`E1PM_DEG_THR_MSB:`E1PM_DEG_THR_LSB] = r.degrade_threshold;
            end
            `E1PM_OFS_STATUS: begin
                rd[`E1PM_ST_TSF_BIT] = r.trail_fail_action;
                rd[`E1PM_ST_DEG_BIT] = r.degraded_flag;
                rd[`E1PM_ST_RDI_BIT] = r.remote_defect_flag;
                rd[`E1PM_ST_RNCI_BIT] = r.crc_interwork_status;
                rd[`E1PM_ST_MFP_BIT] = r.multiframe_present_report;
                rd[`E1PM_ST_DEGRADED_CAUSE_BIT] = r.degraded_cause;
                rd[`E1PM_ST_REMOTE_DEFECT_CAUSE_BIT] = r.remote_defect_cause;
                rd[`E1PM_ST_SERVER_FAIL_CAUSE_BIT] = r.server_fail_cause;
            end
            `E1PM_OFS_NEAR: begin
                rd[15:0] = r.near_error_count;
                rd[`E1PM_CNT_DS_BIT] = r.near_defect_second;
            end
            `E1PM_OFS_FAR: begin
                rd[15:0] = r.far_error_count;
                rd[`E1PM_CNT_DS_BIT] = r.far_defect_second;
            end
            `E1PM_OFS_INT_STATUS: rd[`E1PM_INT_W-1:0] = r.int_status;
            `E1PM_OFS_INT_MASK: rd[`E1PM_INT_W-1:0] = r.int_mask;
            default: rd = '0;
        endcase

        // One wait state: pready rises in the second access cycle.
        next_r.pready = access & ~r.pready;
        next_r.pslverr = 1'b0;
        if (access && !r.pready) begin
            next_r.prdata = pwrite ? 32'h0000_0000 : rd;
            next_r.pslverr = ~reg_mapped(paddr);
        end
        if (access && r.pready && pwrite) begin
            unique case (paddr)
                `E1PM_OFS_CTRL: begin
                    next_r.monitoring_active = pwdata[`E1PM_CTRL_MON_BIT];
                    next_r.remote_defect_report_en = pwdata[`E1PM_CTRL_RDI_REP_BIT];
                    next_r.server_fail_report_en = pwdata[`E1PM_CTRL_SSF_REP_BIT];
                    next_r.termination_point_setting = pwdata[`E1PM_CTRL_TP_BIT];
                    if (pwdata[`E1PM_CTRL_CRC_MSB:`E1PM_CTRL_CRC_LSB] != 2'b11) begin
                        next_r.crc_interwork_setting = e1pm_crc_mode_e'(
                            pwdata[`E1PM_CTRL_CRC_MSB:`E1PM_CTRL_CRC_LSB]);
                    end
                end
                `E1PM_OFS_DEGRADE: begin
                    next_r.degrade_window_count = pwdata[`E1PM_DEG_WIN_MSB:`E1PM_DEG_WIN_LSB];
                    next_r.degrade_threshold = pwdata[`E1PM_DEG_THR_MSB:`E1PM_DEG_THR_LSB];
                end
                `E1PM_OFS_INT_STATUS: w1c = pwdata[`E1PM_INT_W-1:0];
                `E1PM_OFS_INT_MASK: next_r.int_mask = pwdata[`E1PM_INT_W-1:0];
                default: w1c = '0;
            endcase
        end
        // A new event wins over a clear in the same cycle.
        next_r.int_status = (r.int_status & ~w1c) | events;
        next_r.irq = |(next_r.int_status & next_r.int_mask);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            r <= '0;
            r.monitoring_active <= `E1PM_RST_MON;
            r.remote_defect_report_en <= `E1PM_RST_RDI_REP;
            r.server_fail_report_en <= `E1PM_RST_SSF_REP;
            r.crc_interwork_setting <= E1PM_CRC_AUTO;
            r.degrade_window_count <= `E1PM_RST_DEG_WIN;
            r.degrade_threshold <= `E1PM_RST_DEG_THR;
            r.int_mask <= `E1PM_RST_MASK;
        end else begin
            r <= next_r;
        end
    end

    assign pready = r.pready;
    assign prdata = r.prdata;
    assign pslverr = r.pslverr;
    assign trail_fail_action = r.trail_fail_action;
    assign trail_degrade_action = r.trail_degrade_action;
    assign degraded_cause = r.degraded_cause;
    assign remote_defect_cause = r.remote_defect_cause;
    assign server_fail_cause = r.server_fail_cause;
    assign crc_interwork_status = r.crc_interwork_status;
    assign multiframe_present_report = r.multiframe_present_report;
    assign irq = r.irq;
endmodule

// ### verif/e1pm_monitor_chk.sv
`timescale 1ns/1ps
module e1pm_monitor_chk (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Register bus.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    // Line side and actions.
    input wire logic server_fail_in,
    input wire logic multiframe_present_in,
    input wire logic trail_fail_action,
    input wire logic trail_degrade_action,
    input wire logic degraded_cause,
    input wire logic server_fail_cause,
    input wire logic multiframe_present_report
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence access_start;
        psel && $rose(penable) && !pready;
    endsequence
    pready_pulse_a: assert property (pready |=> !pready) else $error("pready held high");
    apb_answer_a: assert property (access_start |=> pready) else $error("answer late");
    err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
    wdata_zero_a: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("read data on a write");
    fail_rise_a: assert property ($rose(server_fail_in) |-> ##[1:5] trail_fail_action)
        else $error("trail fail did not follow");
    fail_fall_a: assert property ($fell(server_fail_in) |-> ##[1:5] !trail_fail_action)
        else $error("trail fail did not clear");
    mfp_follow_a: assert property ($rose(multiframe_present_in) |->
        ##[1:5] multiframe_present_report)
        else $error("multiframe report did not follow");
    deg_clear_a: assert property (!multiframe_present_report [*3] |->
        !trail_degrade_action) else $error("degrade without multiframe");
    ssf_cause_a: assert property (server_fail_cause |-> trail_fail_action)
        else $error("server fail cause without fail");
    deg_cause_a: assert property (degraded_cause |-> trail_degrade_action)
        else $error("degrade cause without degrade");
endmodule

bind e1pm_monitor e1pm_monitor_chk e1pm_monitor_chk_inst (.clk, .rst, .psel, .penable, .pwrite,
    .pready, .prdata, .pslverr, .server_fail_in, .multiframe_present_in, .trail_fail_action,
    .trail_degrade_action, .degraded_cause, .server_fail_cause, .multiframe_present_report);

// ### verif/e1pm_line_gen.sv
`timescale 1ns/1ps
`include "e1pm_consts.svh"

// Frame source: one line bit every four clk cycles, 256 bits a frame, 16 frames a group.
module e1pm_line_gen (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst,
    // Controls.
    input wire logic a_bit,
    input wire logic fas_bad,
    output logic [3:0] bad_sent,
    // Line.
    output logic line_data,
    output logic line_clock,
    output logic frame_start,
    output logic multiframe_start
);
    logic [1:0] div;
    logic [7:0] pos;
    logic [3:0] frm;
    logic bad;
    logic [6:0] fas_word;
    assign fas_word = `E1PM_FAS_WORD;
    assign line_clock = div[1];
    assign frame_start = pos == 8'h00;
    assign multiframe_start = pos == 8'h00 && frm == 4'h0;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div <= 2'h0;
            pos <= 8'h00;
            frm <= 4'h0;
            bad <= 1'b0;
            bad_sent <= 4'h0;
        end else begin
            div <= div + 2'h1;
            if (div == 2'h3) begin
                pos <= pos + 8'h01;
                if (pos == 8'hff) begin
                    frm <= frm + 4'h1;
                end
                if (pos == 8'hff && frm[0]) begin
                    bad <= fas_bad;
                    bad_sent <= bad_sent + {3'h0, fas_bad};
                end
            end
        end
    end
    // The first alignment bit is inverted in a corrupted frame.
    always_comb begin
        if (pos == 8'h00) begin
            line_data = ~frm[0];
        end else if (!frm[0] && pos < 8'h08) begin
            line_data = fas_word[3'h7 - pos[2:0]] ^ (bad && pos == 8'h01);
        end else if (frm[0] && pos < 8'h08) begin
            line_data = (pos == 8'h02) ? a_bit : 1'b1;
        end else begin
            line_data = pos[0];
        end
    end
endmodule

// ### verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q;
    logic pready, pslverr, e, line_data, line_clock, frame_start, multiframe_start;
    logic server_fail_in = 1'b0;
    logic multiframe_present_in = 1'b0;
    logic one_second = 1'b0;
    logic equipment_defect = 1'b0;
    logic a_bit = 1'b0;
    logic fas_bad = 1'b0;
    logic [3:0] bad_sent;
    logic trail_fail_action, trail_degrade_action, degraded_cause, remote_defect_cause;
    logic server_fail_cause, crc_interwork_status, multiframe_present_report, irq;
    int num_errors = 0;
    int tests_run = 0;
    always #20 clk = ~clk;
    e1pm_monitor e1pm_monitor_inst (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .line_data, .line_clock, .frame_start, .multiframe_start,
        .server_fail_in, .multiframe_present_in, .one_second, .equipment_defect,
        .trail_fail_action, .trail_degrade_action, .degraded_cause, .remote_defect_cause,
        .server_fail_cause, .crc_interwork_status, .multiframe_present_report, .irq);
    e1pm_line_gen e1pm_line_gen_inst (.clk, .rst, .a_bit, .fas_bad, .bad_sent, .line_data,
        .line_clock, .frame_start, .multiframe_start);
    task summarize();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            num_errors++;
        end
    endtask
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            num_errors++;
            summarize();
        end
    endtask
    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task tick();
        @(posedge clk);
        one_second <= 1'b1;
        repeat (4) @(posedge clk);
        one_second <= 1'b0;
        repeat (8) @(posedge clk);
    endtask
    task frames(input int n);
        repeat (n * 1030) @(posedge clk);
    endtask
    initial begin
        int i;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(8'h00, 32'h21);
        rd(8'h04, 32'h00640007);
        rd(8'h18, 32'h0);
        rd(8'h08, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, 8'h00, 32'h27);
        frames(2);
        tick();
        fas_bad <= 1'b1;
        for (i = 0; i < 20000 && bad_sent !== 4'h3; i++) @(posedge clk);
        if (i >= 20000) begin
            num_errors++;
            summarize();
        end
        fas_bad <= 1'b0;
        frames(1);
        tick();
        rd(8'h0c, 32'h3);
        rd(8'h10, 32'h0);
        equipment_defect <= 1'b1;
        repeat (10) @(posedge clk);
        equipment_defect <= 1'b0;
        tick();
        rd(8'h0c, 32'h10000);
        a_bit <= 1'b1;
        frames(12);
        rd(8'h08, 32'h44);
        chk({31'h0, remote_defect_cause}, 32'h1);
        tick();
        rd(8'h10, 32'h10000);
        apb(1'b1, 8'h00, 32'h25);
        repeat (4) @(posedge clk);
        chk({31'h0, remote_defect_cause}, 32'h0);
        a_bit <= 1'b0;
        frames(12);
        rd(8'h08, 32'h0);
        server_fail_in <= 1'b1;
        repeat (10) @(posedge clk);
        chk({31'h0, trail_fail_action}, 32'h1);
        chk({31'h0, server_fail_cause}, 32'h1);
        tick();
        rd(8'h0c, 32'h10000);
        apb(1'b1, 8'h00, 32'h14);
        repeat (4) @(posedge clk);
        chk({31'h0, server_fail_cause}, 32'h0);
        server_fail_in <= 1'b0;
        multiframe_present_in <= 1'b1;
        repeat (10) @(posedge clk);
        chk({31'h0, multiframe_present_report}, 32'h1);
        chk({31'h0, crc_interwork_status}, 32'h0);
        // One whole group between two ticks carries exactly two E bits at zero.
        for (i = 0; i < 20000 && multiframe_start !== 1'b1; i++) @(posedge clk);
        if (i >= 20000) begin
            num_errors++;
            summarize();
        end
        tick();
        repeat (16371) @(posedge clk);
        tick();
        rd(8'h10, 32'h2);
        multiframe_present_in <= 1'b0;
        repeat (10) @(posedge clk);
        chk({31'h0, trail_degrade_action}, 32'h0);
        chk({31'h0, degraded_cause}, 32'h0);
        chk({31'h0, irq}, 32'h0);
        apb(1'b1, 8'h18, 32'h1);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h1);
        apb(1'b1, 8'h14, 32'h1f);
        repeat (2) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        rd(8'h14, 32'h0);
        summarize();
    end
endmodule
